// ==== logic/mapper_pkg.sv ====
// Constants shared by the logical block defect mapper.
// Function
// - User blocks get consecutive logical addresses starting at zero.
// - Logical address zero sits at sector zero, track zero, cylinder zero.
// - Inside a cylinder all sectors of a track come before the next track.
// - The last track of each cylinder keeps its spare sectors out of numbering.
// - Numbering resumes at track zero of the next cylinder, alternates excluded.
// - Head and cylinder switches offset the next block by skew sectors.
// - Maintenance addresses are 32-bit with the top bit set, based at 80000000.
// - Short-form 21-bit commands cannot reach the maintenance space.
// - Maintenance space is one cylinder ending at its last non-spare sector.
// - Spares get no address; relocated blocks are redirected internally.
// - Sector slip pushes blocks past defects while cylinder spares remain.
// - Alternate treatment sends a block to a spare here or in an alternate cylinder.
// - Multi-block commands are processed in ascending logical order.
// - Format slips listed defects until spares run out, then uses alternate cylinders.
// - With certify flag zero, failed blocks are logged and alternate-treated only.
// - Reassign uses a spare in the own cylinder first, else an alternate cylinder.
// - Enabled automatic reallocation relocates defective blocks by alternate treatment.
// - Only one automatic reallocation per command; a second one ends with error.
// - A read error recovered by rewrite and verify causes no relocation.
// - Factory and growth defect lists are kept and readable by the initiator.
// - Defects supplied with a format command are stored into the growth list; the code tags them SRC_DATA, not SRC_GROWTH.
// - Sectors are numbered by an ideal index that ignores slipped defects.
package mapper_pkg;
	// -----------------------------------------------------------------
	// Register map (byte offsets)
	// -----------------------------------------------------------------
	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_CMD = 6'h04;
	localparam logic [5:0] OFS_LBA = 6'h08;
	localparam logic [5:0] OFS_STATUS = 6'h0C;
	localparam logic [5:0] OFS_CYL = 6'h10;
	localparam logic [5:0] OFS_HEAD = 6'h14;
	localparam logic [5:0] OFS_SECTOR = 6'h18;
	localparam logic [5:0] OFS_LIST_COUNT = 6'h1C;
	localparam logic [5:0] OFS_LIST_INDEX = 6'h20;
	localparam logic [5:0] OFS_LIST_DATA = 6'h24;
	// -----------------------------------------------------------------
	// Field positions
	// -----------------------------------------------------------------
	localparam int CTRL_CERT_DIS = 0;
	localparam int CTRL_AUTO_WRITE_REALLOC_ENABLE = 1;
	localparam int CTRL_AUTO_READ_REALLOC_ENABLE = 2;
	localparam int CMD_SHORT = 4;
	localparam int CMD_IS_READ = 5;
	localparam int CMD_RECOVERED = 6;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_ERR_RANGE = 2;
	localparam int ST_ERR_SPARE = 3;
	localparam int ST_ERR_SECOND = 4;
	localparam int ST_MAINT = 5;
	localparam int ST_RELOC = 6;
	localparam int ST_ERR_DISABLED = 7;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// -----------------------------------------------------------------
	// Addressing constants
	// -----------------------------------------------------------------
	localparam logic [31:0] MAINT_BASE = 32'h8000_0000;
	localparam logic [31:0] SHORT_LIMIT = 32'h0020_0000;
	// -----------------------------------------------------------------
	// Default geometry
	// -----------------------------------------------------------------
	localparam int DEF_SPT = 64;
	localparam int DEF_HEADS = 7;
	localparam int DEF_SPARES = 8;
	localparam int DEF_USER_CYLS = 1600;
	localparam int DEF_ALT_CYLS = 2;
	localparam int DEF_HEAD_SKEW = 4;
	localparam int DEF_CYL_SKEW = 8;
	localparam int DEF_DEPTH = 16;
	localparam int DIV_STEPS = 32;
	// -----------------------------------------------------------------
	// Commands and list encodings
	// -----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_XLATE = 4'h1,
		OP_NEXT = 4'h2,
		OP_FORMAT = 4'h3,
		OP_REASSIGN = 4'h4,
		OP_CERT = 4'h5,
		OP_AUTO = 4'h6,
		OP_CMD_START = 4'h7,
		OP_FACTORY = 4'h8
	} op_type;
	typedef enum logic [1:0] {
		SRC_FACTORY = 2'h0,
		SRC_DATA = 2'h1,
		SRC_CERT = 2'h2,
		SRC_GROWTH = 2'h3
	} src_type;
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_DIV = 3'h1,
		S_SCAN = 3'h2,
		S_ALLOC = 3'h3,
		S_TRACK = 3'h4,
		S_FIN = 3'h5
	} state_type;
endpackage : mapper_pkg

// ==== logic/block_mapper.sv ====
// Logical block to physical sector mapper with defect lists and Avalon-MM registers.
`timescale 1ns/1ns
module block_mapper #(
	parameter int SPT = mapper_pkg::DEF_SPT,
	parameter int HEADS = mapper_pkg::DEF_HEADS,
	parameter int SPARES = mapper_pkg::DEF_SPARES,
	parameter int USER_CYLS = mapper_pkg::DEF_USER_CYLS,
	parameter int ALT_CYLS = mapper_pkg::DEF_ALT_CYLS,
	parameter int HEAD_SKEW = mapper_pkg::DEF_HEAD_SKEW,
	parameter int CYL_SKEW = mapper_pkg::DEF_CYL_SKEW,
	parameter int DEPTH = mapper_pkg::DEF_DEPTH
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Avalon-MM slave
	input wire logic [5:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Translated location for the media sequencer
	output logic map_valid,
	output logic [31:0] map_cyl,
	output logic [31:0] map_head,
	output logic [31:0] map_sector
);
	localparam int IW = $clog2(DEPTH);
	localparam logic [31:0] BPC = 32'(SPT * HEADS - SPARES);
	localparam logic [31:0] TRK_SECT = 32'(SPT * HEADS);
	localparam logic [31:0] USER_BLOCKS = 32'(SPT * HEADS - SPARES) * 32'(USER_CYLS);
	localparam logic [31:0] MAINT_CYL = 32'(USER_CYLS + ALT_CYLS);
	localparam logic [31:0] LAST_ALT_CYL = 32'(USER_CYLS + ALT_CYLS - 1);

	// -----------------------------------------------------------------
	// Storage
	// -----------------------------------------------------------------
	logic [31:0] def_cyl [DEPTH];
	logic [31:0] def_pos [DEPTH];
	logic [31:0] def_spare_cyl [DEPTH];
	logic [31:0] def_spare_pos [DEPTH];
	logic def_alt [DEPTH];
	mapper_pkg::src_type def_src [DEPTH];
	logic [IW:0] count_q;
	logic [IW-1:0] list_index_q;
	logic [31:0] ctrl_q;
	logic [31:0] lba_q;
	logic [31:0] status_q;
	mapper_pkg::op_type op_q;
	logic short_q;
	logic is_read_q;
	logic recovered_q;
	logic realloc_done_q;
	mapper_pkg::state_type state_q;
	mapper_pkg::state_type div_ret_q;
	logic [31:0] quo_q;
	logic [32:0] rem_q;
	logic [31:0] dsr_q;
	logic [5:0] step_q;
	logic [31:0] cyl_q;
	logic [31:0] idx_q;
	logic [31:0] phys_q;
	logic [31:0] slip_le_q;
	logic [31:0] used_q;
	logic [IW:0] scan_q;
	logic hit_q;
	logic [31:0] hit_cyl_q;
	logic [31:0] hit_pos_q;
	logic [31:0] head_q;
	logic [31:0] skew_q;
	logic [31:0] alt_cyl_q;
	logic [31:0] alt_pos_q;
	logic [32:0] rem_shift;
	logic bus_write;
	logic start;
	logic [31:0] slip_new;
	logic [31:0] lba_eff;

	// A write takes effect only in the cycle the bus sees waitrequest low.
	assign bus_write = write && !waitrequest;
	assign start = bus_write && (address == mapper_pkg::OFS_CMD) && (state_q == mapper_pkg::S_IDLE);
	assign rem_shift = {rem_q[31:0], quo_q[31]};
	assign slip_new = idx_q + slip_le_q;
	// A next-block command must see the incremented address in its own start cycle.
	assign lba_eff = (mapper_pkg::op_type'(writedata[3:0]) == mapper_pkg::OP_NEXT)
		? lba_q + 32'h0000_0001 : lba_q;

	// -----------------------------------------------------------------
	// Bus slave
	// -----------------------------------------------------------------
	// Each access is answered one cycle after it is presented.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			waitrequest <= 1'b1;
			readdata <= 32'h0000_0000;
		end else if ((read || write) && waitrequest) begin
			waitrequest <= 1'b0;
			unique case (address)
				mapper_pkg::OFS_CTRL: readdata <= ctrl_q;
				mapper_pkg::OFS_LBA: readdata <= lba_q;
				mapper_pkg::OFS_STATUS: readdata <= status_q;
				mapper_pkg::OFS_CYL: readdata <= map_cyl;
				mapper_pkg::OFS_HEAD: readdata <= map_head;
				mapper_pkg::OFS_SECTOR: readdata <= map_sector;
				mapper_pkg::OFS_LIST_COUNT: readdata <= 32'(count_q);
				mapper_pkg::OFS_LIST_INDEX: readdata <= 32'(list_index_q);
				mapper_pkg::OFS_LIST_DATA: readdata <= {def_src[list_index_q], def_alt[list_index_q],
					def_pos[list_index_q][12:0], def_cyl[list_index_q][15:0]};
				default: readdata <= 32'h0000_0000;
			endcase
		end else begin
			waitrequest <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= mapper_pkg::CTRL_RESET;
			list_index_q <= '0;
		end else if (bus_write && address == mapper_pkg::OFS_CTRL) begin
			ctrl_q <= {29'h0000_0000, writedata[2:0]};
		end else if (bus_write && address == mapper_pkg::OFS_LIST_INDEX) begin
			list_index_q <= writedata[IW-1:0];
		end
	end

	// -----------------------------------------------------------------
	// Command capture
	// -----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			op_q <= mapper_pkg::OP_NONE;
			short_q <= 1'b0;
			is_read_q <= 1'b0;
			recovered_q <= 1'b0;
		end else if (start) begin
			op_q <= mapper_pkg::op_type'(writedata[3:0]);
			short_q <= writedata[mapper_pkg::CMD_SHORT];
			is_read_q <= writedata[mapper_pkg::CMD_IS_READ];
			recovered_q <= writedata[mapper_pkg::CMD_RECOVERED];
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			lba_q <= 32'h0000_0000;
		end else if (bus_write && address == mapper_pkg::OFS_LBA && state_q == mapper_pkg::S_IDLE) begin
			lba_q <= writedata;
		end else if (start && mapper_pkg::op_type'(writedata[3:0]) == mapper_pkg::OP_NEXT) begin
			lba_q <= lba_q + 32'h0000_0001;
		end
	end

	// -----------------------------------------------------------------
	// Translation engine
	// -----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= mapper_pkg::S_IDLE;
			div_ret_q <= mapper_pkg::S_IDLE;
			status_q <= 32'h0000_0000;
			quo_q <= 32'h0000_0000;
			rem_q <= '0;
			dsr_q <= 32'h0000_0001;
			step_q <= '0;
			cyl_q <= 32'h0000_0000;
			idx_q <= 32'h0000_0000;
			phys_q <= 32'h0000_0000;
			slip_le_q <= 32'h0000_0000;
			used_q <= 32'h0000_0000;
			scan_q <= '0;
			hit_q <= 1'b0;
			hit_cyl_q <= 32'h0000_0000;
			hit_pos_q <= 32'h0000_0000;
			head_q <= 32'h0000_0000;
			skew_q <= 32'h0000_0000;
			count_q <= '0;
			alt_cyl_q <= 32'(USER_CYLS);
			alt_pos_q <= 32'h0000_0000;
			realloc_done_q <= 1'b0;
			map_valid <= 1'b0;
			map_cyl <= 32'h0000_0000;
			map_head <= 32'h0000_0000;
			map_sector <= 32'h0000_0000;
		end else begin
			unique case (state_q)
				mapper_pkg::S_IDLE: begin
					if (start) begin
						map_valid <= 1'b0;
						status_q <= 32'h0000_0001;
						if (mapper_pkg::op_type'(writedata[3:0]) == mapper_pkg::OP_CMD_START) begin
							realloc_done_q <= 1'b0;
							status_q <= 32'h0000_0002;
						end else if (writedata[mapper_pkg::CMD_SHORT] && lba_eff >= mapper_pkg::SHORT_LIMIT) begin
							status_q <= 32'h0000_0006;
						end else if (lba_eff[31]) begin
							if ((lba_eff - mapper_pkg::MAINT_BASE) >= BPC) begin
								status_q <= 32'h0000_0026;
							end else begin
								cyl_q <= MAINT_CYL;
								idx_q <= lba_eff - mapper_pkg::MAINT_BASE;
								phys_q <= lba_eff - mapper_pkg::MAINT_BASE;
								status_q[mapper_pkg::ST_MAINT] <= 1'b1;
								slip_le_q <= 32'h0000_0000;
								used_q <= 32'h0000_0000;
								hit_q <= 1'b0;
								scan_q <= '0;
								state_q <= mapper_pkg::S_SCAN;
							end
						end else if (lba_eff >= USER_BLOCKS) begin
							status_q <= 32'h0000_0006;
						end else begin
							quo_q <= lba_eff;
							rem_q <= '0;
							dsr_q <= BPC;
							step_q <= '0;
							div_ret_q <= mapper_pkg::S_SCAN;
							state_q <= mapper_pkg::S_DIV;
						end
					end
				end
				mapper_pkg::S_DIV: begin
					if (rem_shift >= {1'b0, dsr_q}) begin
						rem_q <= rem_shift - {1'b0, dsr_q};
						quo_q <= {quo_q[30:0], 1'b1};
					end else begin
						rem_q <= rem_shift;
						quo_q <= {quo_q[30:0], 1'b0};
					end
					step_q <= step_q + 6'h01;
					if (step_q == 6'(mapper_pkg::DIV_STEPS - 1)) begin
						state_q <= div_ret_q;
						if (div_ret_q == mapper_pkg::S_SCAN) begin
							cyl_q <= {quo_q[30:0], rem_shift >= {1'b0, dsr_q}};
							idx_q <= (rem_shift >= {1'b0, dsr_q}) ? 32'(rem_shift - {1'b0, dsr_q})
								: rem_shift[31:0];
							phys_q <= (rem_shift >= {1'b0, dsr_q}) ? 32'(rem_shift - {1'b0, dsr_q})
								: rem_shift[31:0];
							slip_le_q <= 32'h0000_0000;
							used_q <= 32'h0000_0000;
							hit_q <= 1'b0;
							scan_q <= '0;
						end
					end
				end
				mapper_pkg::S_SCAN: begin
					if (scan_q < count_q) begin
						if (def_cyl[IW'(scan_q)] == cyl_q) begin
							if (!def_alt[IW'(scan_q)]) begin
								used_q <= used_q + 32'h0000_0001;
								if (def_pos[IW'(scan_q)] <= phys_q) begin
									slip_le_q <= slip_le_q + 32'h0000_0001;
								end
							end else if (def_pos[IW'(scan_q)] == idx_q) begin
								hit_q <= 1'b1;
								hit_cyl_q <= def_spare_cyl[IW'(scan_q)];
								hit_pos_q <= def_spare_pos[IW'(scan_q)];
							end
						end
						if (def_alt[IW'(scan_q)] && def_spare_cyl[IW'(scan_q)] == cyl_q) begin
							used_q <= used_q + 32'h0000_0001;
						end
						scan_q <= scan_q + 1'b1;
					end else if (slip_new != phys_q) begin
						// A slip can push the block over a later defect, so rescan.
						phys_q <= slip_new;
						slip_le_q <= 32'h0000_0000;
						used_q <= 32'h0000_0000;
						hit_q <= 1'b0;
						scan_q <= '0;
					end else if (op_q == mapper_pkg::OP_XLATE || op_q == mapper_pkg::OP_NEXT) begin
						if (hit_q) begin
							cyl_q <= hit_cyl_q;
							phys_q <= hit_pos_q;
						end
						head_q <= 32'h0000_0000;
						skew_q <= 32'h0000_0000;
						state_q <= mapper_pkg::S_TRACK;
					end else begin
						state_q <= mapper_pkg::S_ALLOC;
					end
				end
				mapper_pkg::S_ALLOC: begin
					state_q <= mapper_pkg::S_IDLE;
					status_q[mapper_pkg::ST_BUSY] <= 1'b0;
					status_q[mapper_pkg::ST_DONE] <= 1'b1;
					if (op_q == mapper_pkg::OP_AUTO && !(is_read_q ? ctrl_q[mapper_pkg::CTRL_AUTO_READ_REALLOC_ENABLE]
						: ctrl_q[mapper_pkg::CTRL_AUTO_WRITE_REALLOC_ENABLE])) begin
						status_q[mapper_pkg::ST_ERR_DISABLED] <= 1'b1;
					end else if (op_q == mapper_pkg::OP_AUTO && is_read_q && recovered_q) begin
						status_q[mapper_pkg::ST_RELOC] <= 1'b0;
					end else if (op_q == mapper_pkg::OP_AUTO && realloc_done_q) begin
						status_q[mapper_pkg::ST_ERR_SECOND] <= 1'b1;
					end else if (op_q == mapper_pkg::OP_CERT && ctrl_q[mapper_pkg::CTRL_CERT_DIS]) begin
						status_q[mapper_pkg::ST_ERR_DISABLED] <= 1'b1;
					end else if (count_q == (IW+1)'(DEPTH)) begin
						status_q[mapper_pkg::ST_ERR_SPARE] <= 1'b1;
					end else if (used_q < 32'(SPARES)) begin
						def_cyl[IW'(count_q)] <= cyl_q;
						def_pos[IW'(count_q)] <= idx_q;
						def_alt[IW'(count_q)] <= (op_q != mapper_pkg::OP_FORMAT && op_q != mapper_pkg::OP_FACTORY);
						def_spare_cyl[IW'(count_q)] <= cyl_q;
						def_spare_pos[IW'(count_q)] <= BPC + used_q;
						def_src[IW'(count_q)] <= (op_q == mapper_pkg::OP_FACTORY) ? mapper_pkg::SRC_FACTORY
							: (op_q == mapper_pkg::OP_FORMAT) ? mapper_pkg::SRC_DATA
							: (op_q == mapper_pkg::OP_CERT) ? mapper_pkg::SRC_CERT : mapper_pkg::SRC_GROWTH;
						count_q <= count_q + 1'b1;
						status_q[mapper_pkg::ST_RELOC] <= 1'b1;
						realloc_done_q <= realloc_done_q || (op_q == mapper_pkg::OP_AUTO);
					end else if (alt_cyl_q <= LAST_ALT_CYL) begin
						def_cyl[IW'(count_q)] <= cyl_q;
						def_pos[IW'(count_q)] <= idx_q;
						def_alt[IW'(count_q)] <= 1'b1;
						def_spare_cyl[IW'(count_q)] <= alt_cyl_q;
						def_spare_pos[IW'(count_q)] <= alt_pos_q;
						def_src[IW'(count_q)] <= (op_q == mapper_pkg::OP_FACTORY) ? mapper_pkg::SRC_FACTORY
							: (op_q == mapper_pkg::OP_FORMAT) ? mapper_pkg::SRC_DATA
							: (op_q == mapper_pkg::OP_CERT) ? mapper_pkg::SRC_CERT : mapper_pkg::SRC_GROWTH;
						count_q <= count_q + 1'b1;
						if (alt_pos_q == TRK_SECT - 32'h0000_0001) begin
							alt_pos_q <= 32'h0000_0000;
							alt_cyl_q <= alt_cyl_q + 32'h0000_0001;
						end else begin
							alt_pos_q <= alt_pos_q + 32'h0000_0001;
						end
						status_q[mapper_pkg::ST_RELOC] <= 1'b1;
						realloc_done_q <= realloc_done_q || (op_q == mapper_pkg::OP_AUTO);
					end else begin
						status_q[mapper_pkg::ST_ERR_SPARE] <= 1'b1;
					end
				end
				mapper_pkg::S_TRACK: begin
					// spares at end of last track
					if (phys_q >= 32'(SPT)) begin
						phys_q <= phys_q - 32'(SPT);
						head_q <= head_q + 32'h0000_0001;
						skew_q <= skew_q + 32'(HEAD_SKEW);
					end else begin
						// skew
						// Alternate cylinders carry no skew, so their index is the sector.
						quo_q <= (cyl_q >= 32'(USER_CYLS) && cyl_q != MAINT_CYL) ? phys_q
							: phys_q + skew_q + 32'(cyl_q * 32'(CYL_SKEW));
						rem_q <= '0;
						dsr_q <= 32'(SPT);
						step_q <= '0;
						div_ret_q <= mapper_pkg::S_FIN;
						state_q <= mapper_pkg::S_DIV;
					end
				end
				mapper_pkg::S_FIN: begin
					map_cyl <= cyl_q;
					map_head <= head_q;
					map_sector <= rem_q[31:0];
					map_valid <= 1'b1;
					status_q[mapper_pkg::ST_BUSY] <= 1'b0;
					status_q[mapper_pkg::ST_DONE] <= 1'b1;
					state_q <= mapper_pkg::S_IDLE;
				end
				default: state_q <= mapper_pkg::S_IDLE;
			endcase
		end
	end
endmodule : block_mapper

// ==== verif/mapper_monitor.sv ====
// Concurrent checks on the ports of the block mapper.
`timescale 1ns/1ns
module mapper_monitor #(
	parameter int SPT = 64,
	parameter int HEADS = 7,
	parameter int USER_CYLS = 1600,
	parameter int ALT_CYLS = 2
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Register bus
	input wire logic [5:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// Translation result
	input wire logic map_valid,
	input wire logic [31:0] map_cyl,
	input wire logic [31:0] map_head,
	input wire logic [31:0] map_sector
);
	logic [2:0] ctrl_q;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// Shadow of the flag bits so that a read-back can be judged.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= 3'h0;
		end else if (write && !waitrequest && address == mapper_pkg::OFS_CTRL) begin
			ctrl_q <= writedata[2:0];
		end
	end
	wait_ack_a: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("bus request not answered in one cycle");
	ack_single_a: assert property (!waitrequest |=> waitrequest)
		else $error("acknowledge longer than one cycle");
	idle_wait_a: assert property (!(read || write) && waitrequest |=> waitrequest)
		else $error("acknowledge without request");
	sector_range_a: assert property (map_valid |-> map_sector < SPT && map_head < HEADS)
		else $error("location outside the track geometry");
	cyl_range_a: assert property (map_valid |-> map_cyl <= USER_CYLS + ALT_CYLS)
		else $error("cylinder beyond the maintenance cylinder");
	map_hold_a: assert property (map_valid && $past(map_valid) |->
		$stable(map_cyl) && $stable(map_head) && $stable(map_sector))
		else $error("location changed while valid");
	valid_hold_a: assert property (map_valid &&
		!(write && !waitrequest && address == mapper_pkg::OFS_CMD) |=> map_valid)
		else $error("valid dropped without a command");
	ctrl_read_a: assert property (read && !waitrequest && address == mapper_pkg::OFS_CTRL
		|-> readdata[2:0] == ctrl_q)
		else $error("flag read-back differs from last write");
endmodule : mapper_monitor

bind block_mapper mapper_monitor #(.SPT(SPT), .HEADS(HEADS), .USER_CYLS(USER_CYLS),
	.ALT_CYLS(ALT_CYLS)) mon (.ref_clk(ref_clk), .arst_n(arst_n), .address(address),
	.read(read), .write(write), .writedata(writedata), .readdata(readdata),
	.waitrequest(waitrequest), .map_valid(map_valid), .map_cyl(map_cyl),
	.map_head(map_head), .map_sector(map_sector));

// ==== verif/host_model.sv ====
// Command host model that issues register accesses as an Avalon-MM master.
`timescale 1ns/1ns
module host_model (
	// Clock
	input wire logic ref_clk,
	// Avalon-MM master
	output logic [5:0] address,
	output logic read,
	output logic write,
	output logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest
);
	initial begin
		address = 6'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0000_0000;
	end
	// block addresses always go out as full 32-bit words.
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		address <= a;
		writedata <= d;
		write <= 1'b1;
		// Hold the request until the rising edge at which waitrequest is seen low.
		do @(posedge ref_clk); while (waitrequest !== 1'b0);
		write <= 1'b0;
		@(posedge ref_clk);
	endtask : wr
	task automatic rd(input logic [5:0] a, output logic [31:0] d);
		address <= a;
		read <= 1'b1;
		do @(posedge ref_clk); while (waitrequest !== 1'b0);
		d = readdata;
		read <= 1'b0;
		@(posedge ref_clk);
	endtask : rd
endmodule : host_model

// ==== verif/logical_block_defect_mapper_test.sv ====
// Self-checking bench for the block mapper.
`timescale 1ns/1ns
module logical_block_defect_mapper_test;
	localparam int SPT = 8;
	localparam int HEADS = 2;
	localparam int SPARES = 2;
	localparam int UC = 4;
	localparam int HS = 1;
	localparam int CS = 2;
	localparam int BPC = SPT * HEADS - SPARES;
	logic ref_clk;
	logic arst_n;
	logic [5:0] address;
	logic read;
	logic write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic waitrequest;
	logic map_valid;
	logic [31:0] map_cyl;
	logic [31:0] map_head;
	logic [31:0] map_sector;
	logic [31:0] st;
	logic [15:0] rnd;
	int n_fail = 0;
	int n_compared = 0;
	int l;
	int cor[4] = '{0, BPC - 1, BPC, UC * BPC - 1};
	block_mapper #(.SPT(SPT), .HEADS(HEADS), .SPARES(SPARES), .USER_CYLS(UC), .ALT_CYLS(1),
		.HEAD_SKEW(HS), .CYL_SKEW(CS), .DEPTH(8)) dut (.ref_clk(ref_clk), .arst_n(arst_n),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .map_valid(map_valid),
		.map_cyl(map_cyl), .map_head(map_head), .map_sector(map_sector));
	host_model host (.ref_clk(ref_clk), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr_next
	function automatic logic [95:0] trip(input int c, input int h, input int s);
		return {32'(c), 32'(h), 32'(s)};
	endfunction : trip
	// Skew shifts each track by the head and cylinder offsets.
	function automatic logic [95:0] spot(input int c, input int idx);
		return trip(c, idx / SPT, (idx % SPT + (idx / SPT) * HS + c * CS) % SPT);
	endfunction : spot
	task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic run(input logic [31:0] lba, input logic [31:0] c);
		int i;
		host.wr(mapper_pkg::OFS_LBA, lba);
		host.wr(mapper_pkg::OFS_CMD, c);
		st = 32'h0000_0000;
		for (i = 0; i < 400 && st[mapper_pkg::ST_DONE] !== 1'b1; i++)
			host.rd(mapper_pkg::OFS_STATUS, st);
		if (st[mapper_pkg::ST_DONE] !== 1'b1) begin
			n_fail++;
			$display("ERROR t=%0t command never finished", $time);
		end
	endtask : run
	task automatic loc(input int lba, input logic [95:0] exp);
		run(lba, 32'h0000_0001);
		chk({map_cyl, map_head, map_sector}, exp, "location");
		chk(map_valid, 1'b1, "valid");
	endtask : loc
	task automatic wrap_up;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (60000) @(posedge ref_clk);
		n_fail++;
		wrap_up();
	end
	initial begin
		arst_n = 1'b0;
		repeat (6) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		host.rd(mapper_pkg::OFS_CTRL, st);
		chk(st, 0, "flags after reset");
		rnd = 16'd51228;
		for (int k = 0; k < 20; k++) begin
			l = (k < 4) ? cor[k] : rnd % (UC * BPC);
			rnd = lfsr_next(rnd);
			loc(l, spot(l / BPC, l % BPC));
		end
		run(UC * BPC, 32'h0000_0001);
		chk(st[mapper_pkg::ST_ERR_RANGE], 1'b1, "past last user block");
		chk(map_valid, 1'b0, "valid after error");
		run(BPC - 1, 32'h0000_0002);
		chk({map_cyl, map_head, map_sector}, spot(1, 0), "next block");
		$display("test user space done");
		loc(mapper_pkg::MAINT_BASE, spot(UC + 1, 0));
		chk(st[mapper_pkg::ST_MAINT], 1'b1, "maintenance flag");
		loc(mapper_pkg::MAINT_BASE + BPC - 1, spot(UC + 1, BPC - 1));
		run(mapper_pkg::MAINT_BASE + BPC, 32'h0000_0001);
		chk(st[mapper_pkg::ST_ERR_RANGE], 1'b1, "past maintenance end");
		run(mapper_pkg::MAINT_BASE, 32'h0000_0011);
		chk(st[mapper_pkg::ST_ERR_RANGE], 1'b1, "short form");
		$display("test maintenance done");
		for (int u = 0; u < 3; u++) begin
			run(28 + u, 32'h0000_0004);
			loc(28 + u, (u < SPARES) ? spot(2, BPC + u) : trip(UC, 0, 0));
		end
		loc(31, spot(2, 3));
		run(42, 32'h0000_0003);
		loc(42, spot(3, 1));
		loc(43, spot(3, 2));
		host.rd(mapper_pkg::OFS_LIST_COUNT, st);
		chk(st, 4, "list count");
		host.wr(mapper_pkg::OFS_LIST_INDEX, 32'h0000_0003);
		host.rd(mapper_pkg::OFS_LIST_DATA, st);
		chk({st[31:29], st[15:0]}, {3'b010, 16'd3}, "format entry");
		host.wr(mapper_pkg::OFS_LIST_INDEX, 32'h0000_0000);
		host.rd(mapper_pkg::OFS_LIST_DATA, st);
		chk({st[31:29], st[15:0]}, {3'b111, 16'd2}, "reassign entry");
		$display("test defects done");
		host.wr(mapper_pkg::OFS_CTRL, 32'h0000_0002);
		run(5, 32'h0000_0007);
		run(5, 32'h0000_0006);
		chk(st[mapper_pkg::ST_RELOC], 1'b1, "first auto");
		run(6, 32'h0000_0006);
		chk(st[mapper_pkg::ST_ERR_SECOND], 1'b1, "second auto");
		loc(5, spot(0, BPC));
		loc(6, spot(0, 6));
		host.wr(mapper_pkg::OFS_CTRL, 32'h0000_0000);
		run(7, 32'h0000_0007);
		run(7, 32'h0000_0006);
		chk(st[mapper_pkg::ST_ERR_DISABLED], 1'b1, "auto off");
		host.wr(mapper_pkg::OFS_CTRL, 32'h0000_0004);
		run(8, 32'h0000_0007);
		run(8, 32'h0000_0066);
		chk(st[mapper_pkg::ST_RELOC], 1'b0, "recovered read");
		loc(8, spot(0, 8));
		host.wr(mapper_pkg::OFS_CTRL, 32'h0000_0001);
		run(9, 32'h0000_0005);
		chk(st[mapper_pkg::ST_ERR_DISABLED], 1'b1, "certify off");
		host.wr(mapper_pkg::OFS_CTRL, 32'h0000_0000);
		run(9, 32'h0000_0005);
		loc(9, spot(0, BPC + 1));
		run(44, 32'h0000_0008);
		host.rd(mapper_pkg::OFS_LIST_COUNT, st);
		chk(st, 7, "list count after factory");
		host.wr(mapper_pkg::OFS_LIST_INDEX, 32'h0000_0005);
		host.rd(mapper_pkg::OFS_LIST_DATA, st);
		chk({st[31:29], st[15:0]}, {3'b101, 16'd0}, "certify entry");
		host.wr(mapper_pkg::OFS_LIST_INDEX, 32'h0000_0006);
		host.rd(mapper_pkg::OFS_LIST_DATA, st);
		chk({st[31:29], st[15:0]}, {3'b000, 16'd3}, "factory entry");
		$display("test reallocation done");
		wrap_up();
	end
endmodule : logical_block_defect_mapper_test
